//--- hw/bit_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop level synchroniser
module bit_sync
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds q and nothing else
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : bit_sync

//--- hw/link_byte_if.sv
`timescale 1ns/1ps
// ==========================================================
// bytes from the serial-clock side to the core side
interface link_byte_if;
	logic [7:0] rx_byte;
	logic rx_toggle;
	logic mid_byte;
	modport shifter (output rx_byte, output rx_toggle, output mid_byte);
	modport core (input rx_byte, input rx_toggle, input mid_byte);
endinterface : link_byte_if

//--- hw/lock_pkg.sv
// ==========================================================
// protection and lockdown constants
package lock_pkg;
	localparam int NUM_SECTORS_DEF = 32;
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 16;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS1_WRITE = 8'h01;
	localparam logic [7:0] OP_STATUS2_WRITE = 8'h31;
	localparam logic [7:0] OP_PROTECT_SECTOR = 8'h36;
	localparam logic [7:0] OP_UNPROTECT_SECTOR = 8'h39;
	localparam logic [7:0] OP_SECTOR_LOCKDOWN = 8'h33;
	localparam logic [7:0] LOCKDOWN_CONFIRM = 8'hD0;
	localparam int ST1_LOCK_BIT = 7;
	localparam int ST1_GLOBAL_MSB = 5;
	localparam int ST1_GLOBAL_LSB = 2;
	localparam logic [3:0] GLOBAL_UNPROTECT_CODE = 4'h0;
	localparam logic [3:0] GLOBAL_PROTECT_CODE = 4'hF;
	localparam int ST2_LOCKDOWN_EN_BIT = 4;
	localparam logic PROTECT_RESET_VAL = 1'b1;
	localparam logic [3:0] SYNC_RESET_VAL = 4'hC;
	localparam logic [2:0] IDX_OPCODE = 3'h0;
	localparam logic [2:0] IDX_DATA = 3'h1;
	localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
	localparam logic [2:0] IDX_CONFIRM = 3'h4;
	localparam logic [2:0] IDX_SAT = 3'h7;
	localparam logic [2:0] LEN_OPCODE = 3'h1;
	localparam logic [2:0] LEN_STATUS = 3'h2;
	localparam logic [2:0] LEN_ADDR = 3'h4;
	localparam logic [2:0] LEN_LOCKDOWN = 3'h5;
	localparam int CORE_CLK_PERIOD_NS = 10;
	localparam int LOCKDOWN_COMMIT_TIME_US = 200;
	// longest time, so the count rounds down
	localparam int LOCKDOWN_COMMIT_CYCLES = (LOCKDOWN_COMMIT_TIME_US * 1000) / CORE_CLK_PERIOD_NS;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_FRAME = 3'b010,
		ST_BUSY = 3'b100
	} cmd_state_t;
endpackage : lock_pkg

//--- hw/sector_lock_and_lockdown.sv
`timescale 1ns/1ps
// Operation
// RULE1: hardware lock needs pin asserted and lock bit
// RULE2: hardware lock freezes protection and status writes
// RULE3: clearing lock bit never applies global change
// RULE4: pin asserted: lock bit cleared only by reset
// RULE5: pin deasserted: lock bit may still be set
// RULE6: lock bit rising applies global protect/unprotect
// RULE7: protection follows register only, never the pin
// RULE8: software lock: bit may clear, sector commands ignored
// RULE9: one nonvolatile lockdown bit per sector
// RULE10: lockdown zero allows writes, one read-only
// RULE11: lockdown bit set once, never cleared
// RULE12: reject program/erase to locked down sector
// RULE13: host sets write enable and lockdown enable first
// RULE14: host sends opcode, three address bytes, confirm
// RULE15: bytes after confirmation are ignored
// RULE16: valid frame end sets bit, busy, clears latch
// RULE17: short, wrong confirm or misaligned frame aborts
// RULE18: abort keeps lockdown and enable, clears latch
// RULE19: disabled or frozen: ignore, clear latch, idle
// RULE20: unlocked status 00h/7Fh unprotects/protects all
// RULE21: bytes shifted MSB first on rising clock
module sector_lock_and_lockdown
	import lock_pkg::*;
#(
	parameter int NUM_SECTORS = NUM_SECTORS_DEF,
	parameter int LOCK_CYCLES = LOCKDOWN_COMMIT_CYCLES
)
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic SCK,
	input wire logic CSN,
	input wire logic MOSI,
	input wire logic WPN,
	input wire logic LOCKDOWN_FROZEN,
	input wire logic [NUM_SECTORS-1:0] LOCKDOWN_NV,
	input wire logic PE_REQ,
	input wire logic [ADDR_W-1:0] PE_ADDR,
	output logic WRITE_ENABLE_LATCH,
	output logic PROTECTION_REGS_LOCK_BIT,
	output logic LOCKDOWN_ENABLE_BIT,
	output logic HW_LOCKED,
	output logic SW_LOCKED,
	output logic [NUM_SECTORS-1:0] PROTECT,
	output logic [NUM_SECTORS-1:0] LOCKDOWN,
	output logic BUSY,
	output logic PE_GRANT,
	output logic PE_DENY
);
	localparam int SECT_W = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;
	localparam int CNT_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LOCK_CYCLES - 1);

	// ==========================================================
	// helpers
	function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
		return a[SECTOR_LSB +: SECT_W];
	endfunction : sector_of

	function automatic logic [3:0] global_code(input logic [7:0] d);
		return d[ST1_GLOBAL_MSB:ST1_GLOBAL_LSB];
	endfunction : global_code

	logic rst_meta_reg;
	logic rst_n_reg;
	logic [3:0] sync_vec;
	logic wpn_s;
	logic csn_s;
	logic mid_s;
	logic tog_s;
	logic tog_d_reg;
	logic csn_d_reg;
	logic csn_d2_reg;
	logic byte_evt;
	logic cs_fall;
	logic frame_end;
	cmd_state_t state_reg;
	logic [2:0] byte_cnt_reg;
	logic [7:0] op_reg;
	logic [7:0] data_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic conf_ok_reg;
	logic wel_reg;
	logic protection_regs_lock_bit_reg;
	logic sle_reg;
	logic [NUM_SECTORS-1:0] protect_reg;
	logic [NUM_SECTORS-1:0] lockdown_reg;
	logic [CNT_W-1:0] busy_cnt_reg;
	logic busy_reg;
	logic hw_locked_reg;
	logic sw_locked_reg;
	logic pe_grant_reg;
	logic pe_deny_reg;
	logic hw_lock_now;
	logic frame_ok;
	logic wren;
	logic wrdi;
	logic st1;
	logic st2;
	logic prot;
	logic unprot;
	logic lock_attempt;
	logic lock_ok;
	logic wel_clear;
	logic glob_prot;
	logic glob_unprot;
	logic [SECT_W-1:0] lock_sector;
	logic [SECT_W-1:0] pe_sector;
	logic [NUM_SECTORS-1:0] lock_mask;
	logic [NUM_SECTORS-1:0] lockdown_all;

	// ==========================================================
	// reset release and link crossing
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	link_byte_if lk ();

	spi_byte_shifter u_shifter
	(
		.sck(SCK),
		.csn(CSN),
		.mosi(MOSI),
		.rst_n(rst_n_reg),
		.lk(lk.shifter)
	);

	bit_sync #(.WIDTH(4), .RESET_VAL(SYNC_RESET_VAL)) u_sync
	(
		.clk(CORE_CLK),
		.rst_n(rst_n_reg),
		.d({WPN, CSN, lk.mid_byte, lk.rx_toggle}),
		.q(sync_vec)
	);

	assign wpn_s = sync_vec[3];
	assign csn_s = sync_vec[2];
	assign mid_s = sync_vec[1];
	assign tog_s = sync_vec[0];

	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			tog_d_reg <= 1'b0;
			csn_d_reg <= 1'b1;
			csn_d2_reg <= 1'b1;
		end
		else
		begin
			tog_d_reg <= tog_s;
			csn_d_reg <= csn_s;
			csn_d2_reg <= csn_d_reg;
		end
	end

	assign byte_evt = tog_s ^ tog_d_reg;
	assign cs_fall = csn_d_reg & ~csn_s;
	// one cycle late so a final byte is always taken first
	assign frame_end = csn_d_reg & ~csn_d2_reg;

	// ==========================================================
	// frame sequencing
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (cs_fall)
						state_reg <= ST_FRAME;
				ST_FRAME:
					if (frame_end)
						state_reg <= lock_ok ? ST_BUSY : ST_IDLE; // [RULE19]
				ST_BUSY:
					if (busy_cnt_reg == CNT_LAST)
						state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// frames begun while busy are skipped whole
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			byte_cnt_reg <= IDX_OPCODE;
			op_reg <= 8'h00;
			data_reg <= 8'h00;
			addr_reg <= '0;
			conf_ok_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			byte_cnt_reg <= IDX_OPCODE;
			conf_ok_reg <= 1'b0;
		end
		else if (state_reg == ST_FRAME && byte_evt)
		begin
			if (byte_cnt_reg == IDX_OPCODE)
				op_reg <= lk.rx_byte;
			if (byte_cnt_reg == IDX_DATA)
				data_reg <= lk.rx_byte;
			if (byte_cnt_reg >= IDX_DATA && byte_cnt_reg <= IDX_ADDR_LAST)
				addr_reg <= {addr_reg[ADDR_W-9:0], lk.rx_byte}; // [RULE14]
			if (byte_cnt_reg == IDX_CONFIRM)
				conf_ok_reg <= (lk.rx_byte == LOCKDOWN_CONFIRM); // [RULE14]
			if (byte_cnt_reg != IDX_SAT)
				byte_cnt_reg <= byte_cnt_reg + 3'h1; // [RULE15]
		end
	end

	// ==========================================================
	// command decode at frame end
	always_comb
	begin
		hw_lock_now = ~wpn_s & protection_regs_lock_bit_reg; // [RULE1]
		frame_ok = (state_reg == ST_FRAME) && frame_end && !mid_s; // [RULE17]
		wren = frame_ok && op_reg == OP_WRITE_ENABLE && byte_cnt_reg >= LEN_OPCODE;
		wrdi = frame_ok && op_reg == OP_WRITE_DISABLE && byte_cnt_reg >= LEN_OPCODE;
		st1 = frame_ok && op_reg == OP_STATUS1_WRITE && byte_cnt_reg >= LEN_STATUS
			&& wel_reg && !hw_lock_now; // [RULE2]
		st2 = frame_ok && op_reg == OP_STATUS2_WRITE && byte_cnt_reg >= LEN_STATUS
			&& wel_reg && !hw_lock_now; // [RULE2]
		prot = frame_ok && op_reg == OP_PROTECT_SECTOR && byte_cnt_reg >= LEN_ADDR
			&& wel_reg && !protection_regs_lock_bit_reg; // [RULE2] [RULE8]
		unprot = frame_ok && op_reg == OP_UNPROTECT_SECTOR && byte_cnt_reg >= LEN_ADDR
			&& wel_reg && !protection_regs_lock_bit_reg; // [RULE2] [RULE8]
		lock_attempt = (state_reg == ST_FRAME) && frame_end && op_reg == OP_SECTOR_LOCKDOWN;
		lock_ok = lock_attempt && !mid_s && byte_cnt_reg >= LEN_LOCKDOWN && conf_ok_reg
			&& wel_reg && sle_reg && !LOCKDOWN_FROZEN; // [RULE17] [RULE19]
		wel_clear = (state_reg == ST_FRAME) && frame_end
			&& (op_reg == OP_WRITE_DISABLE || op_reg == OP_STATUS1_WRITE
			|| op_reg == OP_STATUS2_WRITE || op_reg == OP_PROTECT_SECTOR
			|| op_reg == OP_UNPROTECT_SECTOR || op_reg == OP_SECTOR_LOCKDOWN); // [RULE18]
		// only an unlocked bit lets the same write touch every sector
		glob_prot = st1 && !protection_regs_lock_bit_reg
			&& global_code(data_reg) == GLOBAL_PROTECT_CODE; // [RULE3] [RULE6] [RULE20]
		glob_unprot = st1 && !protection_regs_lock_bit_reg
			&& global_code(data_reg) == GLOBAL_UNPROTECT_CODE; // [RULE3] [RULE6] [RULE20]
		lock_sector = sector_of(addr_reg);
		pe_sector = sector_of(PE_ADDR);
		lockdown_all = lockdown_reg | LOCKDOWN_NV;
		lock_mask = '0;
		if (lock_ok)
			lock_mask[lock_sector] = 1'b1; // [RULE16]
	end

	// ==========================================================
	// status bits
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			wel_reg <= 1'b0;
		else if (wren)
			wel_reg <= 1'b1;
		else if (wel_clear || wrdi)
			wel_reg <= 1'b0; // [RULE16] [RULE18] [RULE19]
	end

	// reset stands in for the power cycle
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			protection_regs_lock_bit_reg <= 1'b0;
		else if (st1)
			protection_regs_lock_bit_reg <= data_reg[ST1_LOCK_BIT]; // [RULE4] [RULE5] [RULE8]
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			sle_reg <= 1'b0;
		else if (LOCKDOWN_FROZEN)
			sle_reg <= 1'b0;
		else if (st2)
			sle_reg <= data_reg[ST2_LOCKDOWN_EN_BIT];
	end

	// ==========================================================
	// sector protection and lockdown
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			protect_reg <= {NUM_SECTORS{PROTECT_RESET_VAL}};
		else if (glob_unprot)
			protect_reg <= '0; // [RULE20]
		else if (glob_prot)
			protect_reg <= '1; // [RULE20]
		else if (prot)
			protect_reg[sector_of(addr_reg)] <= 1'b1;
		else if (unprot)
			protect_reg[sector_of(addr_reg)] <= 1'b0;
	end

	// nonvolatile copy refills after reset; bits only ever accumulate
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			lockdown_reg <= '0;
		else
			lockdown_reg <= lockdown_all | lock_mask; // [RULE9] [RULE11] [RULE16]
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			busy_cnt_reg <= '0;
		else if (state_reg == ST_BUSY)
			busy_cnt_reg <= busy_cnt_reg + CNT_W'(1);
		else
			busy_cnt_reg <= '0;
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			busy_reg <= 1'b0;
		else if (lock_ok)
			busy_reg <= 1'b1; // [RULE16]
		else if (state_reg == ST_BUSY && busy_cnt_reg == CNT_LAST)
			busy_reg <= 1'b0;
	end

	// ==========================================================
	// program/erase gate and lock state outputs
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			pe_grant_reg <= 1'b0;
			pe_deny_reg <= 1'b0;
		end
		else
		begin
			// pin not consulted here at all
			pe_grant_reg <= PE_REQ && !lockdown_all[pe_sector]
				&& !protect_reg[pe_sector]; // [RULE7] [RULE10]
			pe_deny_reg <= PE_REQ && (lockdown_all[pe_sector]
				|| protect_reg[pe_sector]); // [RULE7] [RULE12]
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			hw_locked_reg <= 1'b0;
			sw_locked_reg <= 1'b0;
		end
		else
		begin
			hw_locked_reg <= hw_lock_now; // [RULE1]
			sw_locked_reg <= wpn_s & protection_regs_lock_bit_reg;
		end
	end

	assign WRITE_ENABLE_LATCH = wel_reg;
	assign PROTECTION_REGS_LOCK_BIT = protection_regs_lock_bit_reg;
	assign LOCKDOWN_ENABLE_BIT = sle_reg;
	assign HW_LOCKED = hw_locked_reg;
	assign SW_LOCKED = sw_locked_reg;
	assign PROTECT = protect_reg;
	assign LOCKDOWN = lockdown_reg;
	assign BUSY = busy_reg;
	assign PE_GRANT = pe_grant_reg;
	assign PE_DENY = pe_deny_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!rst_n_reg);

	sequence s_lock_commit;
		lock_ok ##1 busy_reg;
	endsequence

	property p_hw_freeze;
		hw_lock_now && frame_end |=> $stable(protection_regs_lock_bit_reg) && $stable(protect_reg);
	endproperty
	a_hw_freeze: assert property (p_hw_freeze) else $error("hardware lock let state change"); // [RULE2]

	property p_hw_sticky;
		!wpn_s && protection_regs_lock_bit_reg |=> protection_regs_lock_bit_reg;
	endproperty
	a_hw_sticky: assert property (p_hw_sticky) else $error("lock bit cleared under pin"); // [RULE4]

	property p_sw_set;
		st1 && data_reg[ST1_LOCK_BIT] |=> protection_regs_lock_bit_reg;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("lock bit not set by status write"); // [RULE5]

	property p_global_prot;
		glob_prot |=> &protect_reg;
	endproperty
	a_global_prot: assert property (p_global_prot) else $error("global protect missed"); // [RULE6]

	property p_global_unprot;
		glob_unprot |=> protect_reg == '0;
	endproperty
	a_global_unprot: assert property (p_global_unprot) else $error("global unprotect missed"); // [RULE20]

	property p_locked_no_global;
		st1 && protection_regs_lock_bit_reg |=> $stable(protect_reg);
	endproperty
	a_locked_no_global: assert property (p_locked_no_global) else $error("global while locked"); // [RULE3]

	property p_sw_sector_ignored;
		frame_ok && protection_regs_lock_bit_reg && (op_reg == OP_PROTECT_SECTOR
			|| op_reg == OP_UNPROTECT_SECTOR) |=> $stable(protect_reg);
	endproperty
	a_sw_sector_ignored: assert property (p_sw_sector_ignored) else $error("sector cmd not ignored"); // [RULE8]

	property p_never_clear;
		1'b1 |=> (($past(lockdown_reg) & ~lockdown_reg) == '0);
	endproperty
	a_never_clear: assert property (p_never_clear) else $error("lockdown bit cleared"); // [RULE11]

	property p_lock_sets;
		s_lock_commit |-> lockdown_reg[$past(lock_sector)] && !wel_reg;
	endproperty
	a_lock_sets: assert property (p_lock_sets) else $error("lockdown not committed"); // [RULE16]

	property p_busy_holds;
		lock_ok |=> busy_reg[*2];
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("commit time cut short"); // [RULE16]

	property p_abort;
		lock_attempt && !lock_ok && !LOCKDOWN_FROZEN |=> !wel_reg && !busy_reg
			&& $stable(sle_reg) && lockdown_reg == $past(lockdown_all);
	endproperty
	a_abort: assert property (p_abort) else $error("aborted lockdown changed state"); // [RULE18]

	property p_pe_deny;
		PE_REQ && lockdown_all[pe_sector] |=> PE_DENY && !PE_GRANT;
	endproperty
	a_pe_deny: assert property (p_pe_deny) else $error("write to locked sector granted"); // [RULE12]
endmodule : sector_lock_and_lockdown

//--- hw/spi_byte_shifter.sv
`timescale 1ns/1ps
// ==========================================================
// serial-clock domain byte assembly
module spi_byte_shifter
(
	input wire logic sck,
	input wire logic csn,
	input wire logic mosi,
	input wire logic rst_n,
	link_byte_if.shifter lk
);
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;

	// chip select high restarts byte alignment; the clock may stop between frames
	always_ff @(posedge sck or posedge csn)
	begin
		if (csn)
			bit_cnt_reg <= 3'h0;
		else
			bit_cnt_reg <= bit_cnt_reg + 3'h1; // [RULE21]
	end

	always_ff @(posedge sck or negedge rst_n)
	begin
		if (!rst_n)
			shift_reg <= 7'h00;
		else
			shift_reg <= {shift_reg[5:0], mosi}; // [RULE21]
	end

	// toggle marks each byte; core reads rx_byte only after seeing it
	always_ff @(posedge sck or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lk.rx_byte <= 8'h00;
			lk.rx_toggle <= 1'b0;
		end
		else if (bit_cnt_reg == 3'h7)
		begin
			lk.rx_byte <= {shift_reg, mosi}; // [RULE21]
			lk.rx_toggle <= ~lk.rx_toggle;
		end
	end

	// kept through chip select rise so the core can judge the boundary
	always_ff @(posedge sck or negedge rst_n)
	begin
		if (!rst_n)
			lk.mid_byte <= 1'b0;
		else
			lk.mid_byte <= (bit_cnt_reg != 3'h7); // [RULE17]
	end
endmodule : spi_byte_shifter

//--- testbench/spi_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side: shifts command frames on its own 12 ns clock
module spi_host_model
(
	output logic sck,
	output logic csn,
	output logic mosi
);
	initial
	begin
		sck = 1'b0;
		csn = 1'b1;
		mosi = 1'b0;
	end

	// ==========================================================
	// frame sender
	// clock stands still between frames; bits may stop mid-byte on purpose
	task automatic send(input logic [7:0] b [$], input int bits);
		csn = 1'b0;
		#5;
		for (int i = 0; i < bits; i++)
		begin
			mosi = b[i / 8][7 - i % 8];
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
		#5;
		csn = 1'b1;
		// released line shows the inverse, never a stale valid bit
		mosi = ~mosi;
	endtask : send
endmodule : spi_host_model

//--- testbench/test_sector_lock_and_lockdown.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench against a behavioural reference
module test_sector_lock_and_lockdown
	import lock_pkg::*;
;
	localparam int NS = 32;
	localparam int LC = 16;
	logic core_clk, rstn, sck, csn, mosi, wpn, frozen, pe_req;
	logic write_enable_latch, lockb, le, hw, sw, busy, grant, deny;
	logic [NS-1:0] nv, prot, ld, prot_m, ld_m;
	logic [ADDR_W-1:0] pe_addr;
	int err_count, tests_run, lock_m, wel_m, le_m, busy_m;
	int seed = 32'h38f74add;

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	sector_lock_and_lockdown #(.NUM_SECTORS(NS), .LOCK_CYCLES(LC)) i_dut
	(
		.CORE_CLK(core_clk), .RSTN(rstn), .SCK(sck), .CSN(csn), .MOSI(mosi), .WPN(wpn),
		.LOCKDOWN_FROZEN(frozen), .LOCKDOWN_NV(nv), .PE_REQ(pe_req), .PE_ADDR(pe_addr),
		.WRITE_ENABLE_LATCH(write_enable_latch), .PROTECTION_REGS_LOCK_BIT(lockb),
		.LOCKDOWN_ENABLE_BIT(le), .HW_LOCKED(hw), .SW_LOCKED(sw), .PROTECT(prot),
		.LOCKDOWN(ld), .BUSY(busy), .PE_GRANT(grant), .PE_DENY(deny)
	);

	spi_host_model i_host (.sck(sck), .csn(csn), .mosi(mosi));

	// ==========================================================
	// compare and report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic check_state();
		chk("write_enable_latch", 32'(wel_m), 32'(write_enable_latch));
		chk("lock_bit", 32'(lock_m), 32'(lockb));
		chk("lockdown_enable_bit", 32'(le_m), 32'(le));
		chk("hw_locked", 32'(!wpn && lock_m), 32'(hw));
		chk("sw_locked", 32'(wpn && lock_m), 32'(sw));
		chk("protect", prot_m, prot);
		chk("lockdown", ld_m | nv, ld);
	endtask : check_state

	// ==========================================================
	// reference model of one frame
	function automatic void model(input logic [7:0] b [$], input int bits);
		bit ok;
		int s;
		ok = (bits % 8 == 0) && wel_m == 1;
		s = (b.size() > 1) ? int'(b[1][4:0]) : 0;
		busy_m = 0;
		case (b[0])
			OP_WRITE_ENABLE: if (bits % 8 == 0) wel_m = 1;
			OP_STATUS1_WRITE:
				if (ok && bits >= 16 && !(!wpn && lock_m == 1))
				begin
					if (lock_m == 0 && b[1][5:2] == GLOBAL_UNPROTECT_CODE) prot_m = '0;
					if (lock_m == 0 && b[1][5:2] == GLOBAL_PROTECT_CODE) prot_m = '1;
					lock_m = int'(b[1][ST1_LOCK_BIT]);
				end
			OP_STATUS2_WRITE:
				if (ok && bits >= 16 && !(!wpn && lock_m == 1))
					le_m = int'(b[1][ST2_LOCKDOWN_EN_BIT] && !frozen);
			OP_PROTECT_SECTOR, OP_UNPROTECT_SECTOR:
				if (ok && bits >= 32 && lock_m == 0) prot_m[s] = (b[0] == OP_PROTECT_SECTOR);
			OP_SECTOR_LOCKDOWN:
				if (ok && bits >= 40 && b[4] == LOCKDOWN_CONFIRM && le_m == 1 && !frozen)
				begin
					ld_m[s] = 1'b1;
					busy_m = LC;
				end
			default: ;
		endcase
		if (b[0] inside {OP_WRITE_DISABLE, OP_STATUS1_WRITE, OP_STATUS2_WRITE, OP_PROTECT_SECTOR,
			OP_UNPROTECT_SECTOR, OP_SECTOR_LOCKDOWN}) wel_m = 0;
	endfunction : model

	// ==========================================================
	// stimulus tasks
	task automatic frame(input logic [7:0] b [$], input int bits);
		int busy_n;
		busy_n = 0;
		i_host.send(b, bits);
		model(b, bits);
		// window also gives the chip-select high time between frames
		repeat (40)
		begin
			@(posedge core_clk);
			// look after the edge, never in the step that launches busy
			#1;
			busy_n += int'(busy === 1'b1);
		end
		chk("busy_cycles", 32'(busy_m), 32'(busy_n));
		check_state();
	endtask : frame

	task automatic wr(input logic [7:0] b [$], input int bits);
		frame('{OP_WRITE_ENABLE}, 8);
		frame(b, bits);
	endtask : wr

	task automatic pe(input logic [ADDR_W-1:0] a);
		int s;
		logic d;
		s = int'(a[SECTOR_LSB +: 5]);
		d = prot_m[s] | ld_m[s] | nv[s];
		// one idle edge keeps back-to-back requests apart
		@(posedge core_clk);
		#1;
		pe_addr = a;
		pe_req = 1'b1;
		@(posedge core_clk);
		#1;
		pe_req = 1'b0;
		chk("pe_grant", 32'(!d), 32'(grant));
		chk("pe_deny", 32'(d), 32'(deny));
	endtask : pe

	task automatic do_reset();
		rstn = 1'b0;
		repeat (20) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		{lock_m, wel_m, le_m} = '0;
		prot_m = '1;
		ld_m = '0;
		check_state();
	endtask : do_reset

	// ==========================================================
	// main sequence
	initial
	begin
		logic [7:0] r;
		{rstn, frozen, pe_req, nv, pe_addr} = '0;
		wpn = 1'b1;
		err_count = 0;
		tests_run = 0;
		do_reset();
		wr('{OP_STATUS1_WRITE, 8'h00}, 16);
		wr('{OP_STATUS1_WRITE, 8'h7F}, 16);
		wr('{OP_UNPROTECT_SECTOR, 8'h05, 8'h12, 8'h34}, 32);
		pe(24'h051234);
		pe(24'h060000);
		wr('{OP_WRITE_DISABLE}, 8);
		wr('{OP_STATUS1_WRITE, 8'hF0}, 16);
		wr('{OP_PROTECT_SECTOR, 8'h05, 8'h00, 8'h00}, 32);
		wr('{OP_STATUS1_WRITE, 8'h3C}, 16);
		wr('{OP_STATUS1_WRITE, 8'hBC}, 16);
		wpn = 1'b0;
		wr('{OP_STATUS1_WRITE, 8'h00}, 16);
		wr('{OP_UNPROTECT_SECTOR, 8'h02, 8'h00, 8'h00}, 32);
		do_reset();
		wpn = 1'b1;
		wr('{OP_STATUS1_WRITE, 8'h00}, 16);
		wr('{OP_STATUS2_WRITE, 8'h10}, 16);
		r = 8'($random(seed)) & 8'h1F;
		wr('{OP_SECTOR_LOCKDOWN, r, 8'($random(seed)), 8'h00, LOCKDOWN_CONFIRM, 8'hFF}, 48);
		pe({r, 16'h0100});
		r = r ^ 8'h01;
		wr('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00}, 32);
		wr('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00, 8'hD1}, 40);
		wr('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00, LOCKDOWN_CONFIRM, 8'h00}, 43);
		frame('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00, LOCKDOWN_CONFIRM}, 40);
		wr('{OP_STATUS2_WRITE, 8'h00}, 16);
		wr('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00, LOCKDOWN_CONFIRM}, 40);
		wr('{OP_STATUS2_WRITE, 8'h10}, 16);
		frozen = 1'b1;
		le_m = 0;
		wr('{OP_SECTOR_LOCKDOWN, r, 8'h00, 8'h00, LOCKDOWN_CONFIRM}, 40);
		repeat (16) pe(24'($random(seed)));
		// stand-in for the nonvolatile store across a reset
		nv = nv | ld_m;
		do_reset();
		pe({r ^ 8'h01, 16'h0000});
		tally_and_finish();
	end

	initial
	begin
		#300000;
		err_count++;
		tally_and_finish();
	end
endmodule : test_sector_lock_and_lockdown
